/* core/vcarb_regs.sv */
// channel arbitration configuration registers behind an ahb-lite slave
// assumes table storage and arbiters sit outside and use the strobes here
`timescale 1ns/100ps
`include "vcarb_consts.svh"
module vcarb_regs #(
    parameter int LOAD_CYCLES = `VCARB_LOAD_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire vcarb_pkg::vcarb_word_t haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire vcarb_pkg::vcarb_word_t hwdata,
    input wire logic hready,
    output logic hreadyout,
    output vcarb_pkg::vcarb_word_t hrdata,
    output logic hresp,
    input wire logic ee_load_valid,
    input wire logic [7:0] ee_tc_map,
    input wire logic [6:0] ee_max_slots,
    input wire logic vc_entry_wr,
    input wire logic port_entry_wr,
    output vcarb_pkg::vcarb_sel_t vc_arb_scheme,
    output logic vc_table_busy,
    output logic vc_table_status,
    output logic vc_table_apply,
    output vcarb_pkg::vcarb_sel_t port_arb_scheme,
    output logic port_table_busy,
    output logic port_table_status,
    output logic port_table_apply,
    output logic [7:0] tc_map,
    output logic vc_enable
);
    import vcarb_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    vcarb_reg_if rif();

    vcarb_sel_t vc_sel_ff;
    vcarb_sel_t pa_sel_ff;
    logic [7:0] tc_map_ff;
    logic [6:0] mts_ff;
    logic vc_en_ff;
    logic vc_load_ff;
    logic pa_load_ff;
    logic wr_ctrl;
    logic wr_res;
    vcarb_sel_t wr_vc_sel;
    vcarb_sel_t wr_pa_sel;
    vcarb_word_t rdata;

    vcarb_ahb_slave u_bus (
        .clk(clk),
        .rst_n(rst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .rif(rif.bus)
    );

    assign wr_ctrl = rif.wr && (rif.addr == `VCARB_OFF_PORT_CTRL);
    assign wr_res = rif.wr && (rif.addr == `VCARB_OFF_RES_CTRL);
    assign wr_vc_sel = rif.wdata[`VCARB_VC_SEL_MSB:`VCARB_VC_SEL_LSB];
    assign wr_pa_sel = rif.wdata[`VCARB_PA_SEL_MSB:`VCARB_PA_SEL_LSB];

    // unsupported scheme codes fall back to the default scheme
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vc_sel_ff <= `VCARB_VC_SEL_RST;
        end else if (wr_ctrl) begin
            if (wr_vc_sel == `VCARB_VC_SEL_ALT) begin
                vc_sel_ff <= `VCARB_VC_SEL_ALT;
            end else begin
                vc_sel_ff <= `VCARB_VC_SEL_RST;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pa_sel_ff <= `VCARB_PA_SEL_RST;
        end else if (wr_res) begin
            if (wr_pa_sel == `VCARB_PA_SEL_ALT) begin
                pa_sel_ff <= `VCARB_PA_SEL_ALT;
            end else begin
                pa_sel_ff <= `VCARB_PA_SEL_RST;
            end
        end
    end

    // load bits are not stored; each written one is a single pulse
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vc_load_ff <= 1'b0;
            pa_load_ff <= 1'b0;
        end else begin
            vc_load_ff <= wr_ctrl && rif.wdata[`VCARB_VC_LOAD_BIT];
            pa_load_ff <= wr_res && rif.wdata[`VCARB_PA_LOAD_BIT];
        end
    end

    // a software write in the same cycle as an autoload wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tc_map_ff <= `VCARB_TC_RST;
        end else if (wr_res) begin
            tc_map_ff <= rif.wdata[`VCARB_TC_MSB:0];
        end else if (ee_load_valid) begin
            tc_map_ff <= ee_tc_map;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vc_en_ff <= `VCARB_VC_EN_RST;
        end else if (wr_res) begin
            vc_en_ff <= rif.wdata[`VCARB_VC_EN_BIT];
        end
    end

    // read-only to software; only the autoload path can change it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mts_ff <= `VCARB_MTS_RST;
        end else if (ee_load_valid) begin
            mts_ff <= ee_max_slots;
        end
    end

    vcarb_tbl_loader #(
        .LOAD_CYCLES(LOAD_CYCLES)
    ) u_vc_loader (
        .clk(clk),
        .rst_n(rst_n),
        .load_req(vc_load_ff),
        .entry_wr(vc_entry_wr),
        .busy(vc_table_busy),
        .status(vc_table_status),
        .apply(vc_table_apply)
    );

    vcarb_tbl_loader #(
        .LOAD_CYCLES(LOAD_CYCLES)
    ) u_pa_loader (
        .clk(clk),
        .rst_n(rst_n),
        .load_req(pa_load_ff),
        .entry_wr(port_entry_wr),
        .busy(port_table_busy),
        .status(port_table_status),
        .apply(port_table_apply)
    );

    // every bit not named below stays zero, covering reserved ranges
    always_comb begin
        rdata = `VCARB_ZERO_WORD;
        case (rif.addr)
            `VCARB_OFF_PORT_CTRL: begin
                rdata[`VCARB_VC_LOAD_BIT] = 1'b0;
                rdata[`VCARB_VC_SEL_MSB:`VCARB_VC_SEL_LSB] = vc_sel_ff;
                rdata[`VCARB_VC_STAT_BIT] = vc_table_status;
            end
            `VCARB_OFF_RES_CAP: begin
                rdata[`VCARB_PA_CAP_MSB:0] = `VCARB_PA_CAP_VAL;
                rdata[`VCARB_APS_BIT] = 1'b0;
                rdata[`VCARB_SNOOP_BIT] = 1'b0;
                rdata[`VCARB_MTS_MSB:`VCARB_MTS_LSB] = mts_ff;
                rdata[`VCARB_PAT_OFF_MSB:`VCARB_PAT_OFF_LSB] =
                    `VCARB_PAT_OFF_VAL;
            end
            `VCARB_OFF_RES_CTRL: begin
                rdata[`VCARB_TC_MSB:0] = tc_map_ff;
                rdata[`VCARB_PA_LOAD_BIT] = 1'b0;
                rdata[`VCARB_PA_SEL_MSB:`VCARB_PA_SEL_LSB] = pa_sel_ff;
                rdata[`VCARB_VCID_MSB:`VCARB_VCID_LSB] =
                    `VCARB_VCID_VAL;
                rdata[`VCARB_VC_EN_BIT] = vc_en_ff;
            end
            default: rdata = `VCARB_ZERO_WORD;
        endcase
    end

    assign rif.rdata = rdata;
    assign vc_arb_scheme = vc_sel_ff;
    assign port_arb_scheme = pa_sel_ff;
    assign tc_map = tc_map_ff;
    assign vc_enable = vc_en_ff;

    a_vc_load_pulse: assert property (
        (wr_ctrl && rif.wdata[`VCARB_VC_LOAD_BIT])
        |=> vc_load_ff ##1 (!vc_load_ff && vc_table_busy))
        else $error("channel table load did not start");
    a_ctrl_read: assert property (
        (rif.rd && rif.addr == `VCARB_OFF_PORT_CTRL)
        |-> (rdata[`VCARB_VC_LOAD_BIT] == 1'b0
            && rdata[`VCARB_VC_STAT_BIT] == vc_table_status
            && rdata[15:4] == 12'h000))
        else $error("port control readback wrong");
    a_vc_sel_fold: assert property (
        (wr_ctrl && wr_vc_sel != `VCARB_VC_SEL_ALT)
        |=> vc_sel_ff == `VCARB_VC_SEL_RST)
        else $error("channel scheme not folded to default");
    a_vc_sel_keep: assert property (
        !wr_ctrl |=> $stable(vc_sel_ff))
        else $error("channel scheme changed without a write");
    a_cap_word: assert property (
        rif.rd && rif.addr == `VCARB_OFF_RES_CAP
        |-> (rdata[7:0] == 8'h09 && rdata[31:24] == 8'h04
            && rdata[15:8] == 8'h00 && rdata[23] == 1'b0))
        else $error("capability word wrong");
    a_mts_load: assert property (
        ee_load_valid |=> mts_ff == $past(ee_max_slots))
        else $error("maximum time slots not loaded");
    a_tc_write: assert property (
        wr_res |=> tc_map == $past(rif.wdata[7:0]))
        else $error("traffic class map not written");
    a_pa_load_pulse: assert property (
        (wr_res && rif.wdata[`VCARB_PA_LOAD_BIT]) |=> ##1 port_table_busy)
        else $error("port table load did not start");
    a_pa_sel_fold: assert property (
        (wr_res && wr_pa_sel != `VCARB_PA_SEL_ALT)
        |=> port_arb_scheme == 3'h0)
        else $error("port scheme not folded to default");
    a_res_ctrl_read: assert property (
        rif.rd && rif.addr == `VCARB_OFF_RES_CTRL
        |-> (rdata[26:16] == {3'h0, 4'h0, pa_sel_ff, 1'b0}
            && rdata[30:27] == 4'h0 && rdata[15:8] == 8'h00))
        else $error("resource control readback wrong");
    a_vc_en_write: assert property (
        wr_res |=> vc_enable == $past(rif.wdata[`VCARB_VC_EN_BIT]))
        else $error("channel enable not written");
    a_unmapped: assert property (
        (rif.rd && rif.addr != `VCARB_OFF_PORT_CTRL
            && rif.addr != `VCARB_OFF_RES_CAP
            && rif.addr != `VCARB_OFF_RES_CTRL) |-> rdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    // stored fields move only on their own write or on autoload
    a_vc_sel_alt: assert property (
        (wr_ctrl && wr_vc_sel == `VCARB_VC_SEL_ALT)
        |=> vc_arb_scheme == `VCARB_VC_SEL_ALT)
        else $error("channel scheme one not kept");
    a_pa_sel_alt: assert property (
        (wr_res && wr_pa_sel == `VCARB_PA_SEL_ALT)
        |=> port_arb_scheme == `VCARB_PA_SEL_ALT)
        else $error("port scheme three not kept");
    a_pa_sel_keep: assert property (
        !wr_res
        |=> $stable(pa_sel_ff))
        else $error("port scheme changed without a write");
    a_vc_load_quiet: assert property (
        !(wr_ctrl && rif.wdata[`VCARB_VC_LOAD_BIT])
        |=> !vc_load_ff)
        else $error("channel table load without a write");
    a_pa_load_quiet: assert property (
        !(wr_res && rif.wdata[`VCARB_PA_LOAD_BIT])
        |=> !pa_load_ff)
        else $error("port table load without a write");
    a_tc_autoload: assert property (
        (ee_load_valid && !wr_res)
        |=> tc_map == $past(ee_tc_map))
        else $error("traffic class map not autoloaded");
    a_tc_keep: assert property (
        (!wr_res && !ee_load_valid)
        |=> $stable(tc_map_ff))
        else $error("traffic class map changed on its own");
    a_mts_keep: assert property (
        !ee_load_valid
        |=> $stable(mts_ff))
        else $error("maximum time slots changed on its own");
    a_vc_en_keep: assert property (
        !wr_res
        |=> $stable(vc_en_ff))
        else $error("channel enable changed without a write");
    a_mts_read: assert property (
        (rif.rd && rif.addr == `VCARB_OFF_RES_CAP)
        |-> rdata[`VCARB_MTS_MSB:`VCARB_MTS_LSB] == mts_ff)
        else $error("maximum time slots readback wrong");
    a_aps_zero: assert property (
        (rif.rd && rif.addr == `VCARB_OFF_RES_CAP)
        |-> !rdata[`VCARB_APS_BIT])
        else $error("packet switching bit not zero");
    a_snoop_zero: assert property (
        (rif.rd && rif.addr == `VCARB_OFF_RES_CAP)
        |-> !rdata[`VCARB_SNOOP_BIT])
        else $error("snoop rejection bit not zero");
    a_tc_read: assert property (
        (rif.rd && rif.addr == `VCARB_OFF_RES_CTRL)
        |-> rdata[`VCARB_TC_MSB:0] == tc_map_ff)
        else $error("traffic class map readback wrong");
    a_en_read: assert property (
        (rif.rd && rif.addr == `VCARB_OFF_RES_CTRL)
        |-> rdata[`VCARB_VC_EN_BIT] == vc_en_ff)
        else $error("channel enable readback wrong");
endmodule : vcarb_regs

/* core/vcarb_consts.svh */
// constants for the channel arbitration configuration registers
// assumes byte addressing on a 32-bit register bus, one word per register
`ifndef VCARB_CONSTS_SVH
`define VCARB_CONSTS_SVH
`define VCARB_OFF_PORT_CTRL 32'h0000_014C
`define VCARB_OFF_RES_CAP 32'h0000_0150
`define VCARB_OFF_RES_CTRL 32'h0000_0154
`define VCARB_ZERO_WORD 32'h0000_0000
`define VCARB_VC_LOAD_BIT 0
`define VCARB_VC_SEL_LSB 1
`define VCARB_VC_SEL_MSB 3
`define VCARB_VC_SEL_RST 3'h0
`define VCARB_VC_SEL_ALT 3'h1
`define VCARB_VC_STAT_BIT 16
`define VCARB_PA_CAP_MSB 7
`define VCARB_PA_CAP_VAL 8'h09
`define VCARB_APS_BIT 14
`define VCARB_SNOOP_BIT 15
`define VCARB_MTS_LSB 16
`define VCARB_MTS_MSB 22
`define VCARB_MTS_RST 7'h7F
`define VCARB_PAT_OFF_LSB 24
`define VCARB_PAT_OFF_MSB 31
`define VCARB_PAT_OFF_VAL 8'h04
`define VCARB_TC_MSB 7
`define VCARB_TC_RST 8'hFF
`define VCARB_PA_LOAD_BIT 16
`define VCARB_PA_SEL_LSB 17
`define VCARB_PA_SEL_MSB 19
`define VCARB_PA_SEL_RST 3'h0
`define VCARB_PA_SEL_ALT 3'h3
`define VCARB_VCID_LSB 24
`define VCARB_VCID_MSB 26
`define VCARB_VCID_VAL 3'h0
`define VCARB_VC_EN_BIT 31
`define VCARB_VC_EN_RST 1'b1
`define VCARB_LOAD_CYCLES 4
`define VCARB_HTRANS_NONSEQ_BIT 1
`endif

/* core/vcarb_pkg.sv */
// types shared by the channel arbitration register block
// assumes the constants header is compiled alongside
package vcarb_pkg;
    typedef logic [31:0] vcarb_word_t;
    typedef logic [2:0] vcarb_sel_t;
    typedef enum logic [1:0] {VCARB_BUS_IDLE, VCARB_BUS_WAIT, VCARB_BUS_DONE}
        vcarb_bus_state_t;
    typedef enum logic {VCARB_LD_IDLE, VCARB_LD_RUN} vcarb_load_state_t;
endpackage : vcarb_pkg

/* core/vcarb_reg_if.sv */
// register access strobes between the bus slave and the register file
// assumes one clock domain; strobes last one cycle
`timescale 1ns/100ps
interface vcarb_reg_if;
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport bus (output wr, output rd, output addr, output wdata,
        input rdata);
    modport regs (input wr, input rd, input addr, input wdata,
        output rdata);
endinterface : vcarb_reg_if

/* core/vcarb_ahb_slave.sv */
// ahb-lite slave: one wait state on every transfer, always okay
// assumes single word transfers; hsize is not checked
`timescale 1ns/100ps
`include "vcarb_consts.svh"
module vcarb_ahb_slave (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire vcarb_pkg::vcarb_word_t haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire vcarb_pkg::vcarb_word_t hwdata,
    input wire logic hready,
    output logic hreadyout,
    output vcarb_pkg::vcarb_word_t hrdata,
    output logic hresp,
    vcarb_reg_if.bus rif
);
    import vcarb_pkg::*;
    vcarb_bus_state_t state_ff;
    logic write_ff;
    vcarb_word_t addr_ff;
    vcarb_word_t hrdata_ff;
    logic take;

    assign take = hsel && htrans[`VCARB_HTRANS_NONSEQ_BIT] && hready;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= VCARB_BUS_IDLE;
        end else begin
            case (state_ff)
                VCARB_BUS_IDLE: state_ff <= take ? VCARB_BUS_WAIT : state_ff;
                VCARB_BUS_WAIT: state_ff <= VCARB_BUS_DONE;
                VCARB_BUS_DONE: begin
                    state_ff <= take ? VCARB_BUS_WAIT : VCARB_BUS_IDLE;
                end
                default: state_ff <= VCARB_BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            write_ff <= 1'b0;
            addr_ff <= `VCARB_ZERO_WORD;
        end else if (take) begin
            write_ff <= hwrite;
            addr_ff <= haddr;
        end
    end

    // read data is registered so the wait state carries the decode delay
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hrdata_ff <= `VCARB_ZERO_WORD;
        end else if (state_ff == VCARB_BUS_WAIT && !write_ff) begin
            hrdata_ff <= rif.rdata;
        end
    end

    assign rif.wr = (state_ff == VCARB_BUS_WAIT) && write_ff;
    assign rif.rd = (state_ff == VCARB_BUS_WAIT) && !write_ff;
    assign rif.addr = addr_ff;
    assign rif.wdata = hwdata;
    assign hreadyout = (state_ff != VCARB_BUS_WAIT);
    assign hrdata = hrdata_ff;
    assign hresp = 1'b0;
endmodule : vcarb_ahb_slave

/* core/vcarb_tbl_loader.sv */
// arbitration table load sequencer with its written-entry status flag
// assumes entry_wr and load_req are single-cycle pulses on clk
`timescale 1ns/100ps
`include "vcarb_consts.svh"
module vcarb_tbl_loader #(
    parameter int LOAD_CYCLES = `VCARB_LOAD_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load_req,
    input wire logic entry_wr,
    output logic busy,
    output logic status,
    output logic apply
);
    import vcarb_pkg::*;
    localparam int CW = $clog2(LOAD_CYCLES + 1);
    vcarb_load_state_t state_ff;
    logic [CW-1:0] cnt_ff;
    logic status_ff;
    logic apply_ff;
    logic done;

    assign done = (state_ff == VCARB_LD_RUN) && (cnt_ff == '0);

    // a load request during a running load is ignored
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= VCARB_LD_IDLE;
            cnt_ff <= '0;
        end else begin
            case (state_ff)
                VCARB_LD_IDLE: begin
                    if (load_req) begin
                        state_ff <= VCARB_LD_RUN;
                        cnt_ff <= CW'(LOAD_CYCLES - 1);
                    end
                end
                VCARB_LD_RUN: begin
                    if (done) begin
                        state_ff <= VCARB_LD_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                default: state_ff <= VCARB_LD_IDLE;
            endcase
        end
    end

    // set wins over clear so an entry written at load end is not lost
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_ff <= 1'b0;
        end else if (entry_wr) begin
            status_ff <= 1'b1;
        end else if (done) begin
            status_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            apply_ff <= 1'b0;
        end else begin
            apply_ff <= done;
        end
    end

    assign busy = (state_ff == VCARB_LD_RUN);
    assign status = status_ff;
    assign apply = apply_ff;

    a_status_set: assert property (@(posedge clk) disable iff (!rst_n)
        entry_wr |=> status)
        else $error("table status not set after entry write");
    a_status_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (busy && cnt_ff == '0 && !entry_wr) |=> (!status && apply && !busy))
        else $error("table status not cleared at load end");
endmodule : vcarb_tbl_loader

/* testbench/test_vc_arbitration_config_regs.sv */
// self-checking bench for the channel arbitration configuration registers
// assumes the design package, header and modules compile ahead of this file
`timescale 1ns/100ps
`include "vcarb_consts.svh"
module test_vc_arbitration_config_regs;
    import vcarb_pkg::*;
    localparam int LC = 3;
    localparam int LIMIT = 5000;
    logic clk;
    logic rst_n;
    logic hsel;
    vcarb_word_t haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    vcarb_word_t hwdata;
    logic hreadyout;
    vcarb_word_t hrdata;
    logic hresp;
    logic ee_load_valid;
    logic [7:0] ee_tc_map;
    logic [6:0] ee_max_slots;
    logic vc_entry_wr;
    logic port_entry_wr;
    vcarb_sel_t vc_arb_scheme;
    logic vc_table_busy;
    logic vc_table_status;
    logic vc_table_apply;
    vcarb_sel_t port_arb_scheme;
    logic port_table_busy;
    logic port_table_status;
    logic port_table_apply;
    logic [7:0] tc_map;
    logic vc_enable;
    int miscompares;
    int n_checks;
    int cycles;

    vcarb_regs #(.LOAD_CYCLES(LC)) u_vcarb_regs (.clk(clk), .rst_n(rst_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .ee_load_valid(ee_load_valid), .ee_tc_map(ee_tc_map),
        .ee_max_slots(ee_max_slots), .vc_entry_wr(vc_entry_wr),
        .port_entry_wr(port_entry_wr), .vc_arb_scheme(vc_arb_scheme),
        .vc_table_busy(vc_table_busy), .vc_table_status(vc_table_status),
        .vc_table_apply(vc_table_apply), .port_arb_scheme(port_arb_scheme),
        .port_table_busy(port_table_busy),
        .port_table_status(port_table_status),
        .port_table_apply(port_table_apply), .tc_map(tc_map),
        .vc_enable(vc_enable));

    always #10 clk = ~clk;

    task results;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    // a hang counts as a mismatch and still reaches the report
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares = miscompares + 1;
            results();
        end
    end

    task chk(input vcarb_word_t got, input vcarb_word_t exp, input string m);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m,
                got, exp);
        end
    endtask : chk

    // one single transfer; ready is looked at on each falling edge, half a cycle before the rising edge
    task ahb(input logic w, input vcarb_word_t a, input vcarb_word_t d,
        output vcarb_word_t r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(negedge clk); while (hreadyout !== 1'b1);
        @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(negedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
        chk(hresp, 32'h0000_0000, "response");
        @(posedge clk);
    endtask : ahb

    task wr(input vcarb_word_t a, input vcarb_word_t d);
        vcarb_word_t r;
        ahb(1'b1, a, d, r);
    endtask : wr

    task rd(input vcarb_word_t a, input vcarb_word_t exp, input string m);
        vcarb_word_t r;
        ahb(1'b0, a, 32'h0000_0000, r);
        chk(r, exp, m);
    endtask : rd

    // busy must last exactly LC cycles, then one apply pulse follows, with status already cleared at the same edge
    task load_wait(input logic port, input string m);
        int nb;
        int na;
        nb = 0;
        na = 0;
        repeat (LC + 6) begin
            @(negedge clk);
            nb += ((port ? port_table_busy : vc_table_busy) === 1'b1);
            na += ((port ? port_table_apply : vc_table_apply) === 1'b1);
        end
        chk(nb, LC, m);
        chk(na, 1, m);
        chk(port ? port_table_status : vc_table_status, 0, m);
        @(posedge clk);
    endtask : load_wait

    task t_reset_values;
        rd(`VCARB_OFF_PORT_CTRL, 32'h0000_0000, "ctrl rst");
        rd(`VCARB_OFF_RES_CAP, 32'h047F_0009, "cap rst");
        rd(`VCARB_OFF_RES_CAP, 32'h047F_0009, "cap");
        rd(`VCARB_OFF_RES_CTRL, 32'h8000_00FF, "rctl rst");
        chk({vc_enable, tc_map}, 32'h0000_01FF, "outs rst");
    endtask : t_reset_values

    task t_vc_scheme;
        for (int s = 0; s < 8; s++) begin
            wr(`VCARB_OFF_PORT_CTRL, {20'hF_FFFF, s[2:0], 1'b0});
            rd(`VCARB_OFF_PORT_CTRL, (s == 1) ? 32'h0000_0002 :
                32'h0000_0000, "vc scheme");
            chk(vc_arb_scheme, (s == 1) ? 1 : 0, "vc sch out");
        end
    endtask : t_vc_scheme

    task t_vc_load;
        vc_entry_wr <= 1'b1;
        @(posedge clk);
        vc_entry_wr <= 1'b0;
        @(posedge clk);
        rd(`VCARB_OFF_PORT_CTRL, 32'h0001_0000, "vc status");
        wr(`VCARB_OFF_PORT_CTRL, 32'h0000_0003);
        load_wait(1'b0, "vc load");
        rd(`VCARB_OFF_PORT_CTRL, 32'h0000_0002, "vc after");
    endtask : t_vc_load

    task t_res_ctrl;
        logic [7:0] tc;
        for (int s = 0; s < 8; s++) begin
            tc = {s[2:0], ~s[2:0], 2'b10};
            wr(`VCARB_OFF_RES_CTRL, {s[0], 7'h7F, 4'hF, s[2:0], 1'b0,
                8'hFF, tc});
            rd(`VCARB_OFF_RES_CTRL, {s[0], 11'h000, (s == 3) ? 3'h3 :
                3'h0, 1'b0, 8'h00, tc}, "res ctrl");
            chk({port_arb_scheme, vc_enable, tc_map}, {(s == 3) ? 3'h3 :
                3'h0, s[0], tc}, "res outs");
        end
    endtask : t_res_ctrl

    task t_port_load;
        port_entry_wr <= 1'b1;
        @(posedge clk);
        port_entry_wr <= 1'b0;
        @(posedge clk);
        chk(port_table_status, 1, "port status");
        wr(`VCARB_OFF_RES_CTRL, 32'h8001_00FF);
        load_wait(1'b1, "port load");
        rd(`VCARB_OFF_RES_CTRL, 32'h8000_00FF, "port after");
    endtask : t_port_load

    task t_autoload;
        ee_tc_map <= 8'h5A;
        ee_max_slots <= 7'h12;
        ee_load_valid <= 1'b1;
        @(posedge clk);
        ee_load_valid <= 1'b0;
        @(posedge clk);
        rd(`VCARB_OFF_RES_CAP, 32'h0412_0009, "ee slots");
        rd(`VCARB_OFF_RES_CTRL, 32'h8000_005A, "ee tc map");
    endtask : t_autoload

    // read-only word and unmapped places must shrug off writes
    task t_read_only;
        wr(`VCARB_OFF_RES_CAP, 32'hFFFF_FFFF);
        rd(`VCARB_OFF_RES_CAP, 32'h0412_0009, "cap ro");
        for (int i = 0; i < 2; i++) begin
            wr(i ? 32'h0000_0158 : 32'h0000_0148, 32'hFFFF_FFFF);
            rd(i ? 32'h0000_0158 : 32'h0000_0148, 32'h0000_0000,
                "unmapped");
        end
    endtask : t_read_only

    // a second reset in mid-run must bring back every reset value
    task t_rereset;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset_values();
    endtask : t_rereset

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        ee_load_valid = 1'b0;
        ee_tc_map = 8'h00;
        ee_max_slots = 7'h00;
        vc_entry_wr = 1'b0;
        port_entry_wr = 1'b0;
        miscompares = 0;
        n_checks = 0;
        cycles = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset_values();
        t_vc_scheme();
        t_vc_load();
        t_res_ctrl();
        t_port_load();
        t_autoload();
        t_read_only();
        t_rereset();
        results();
    end
endmodule : test_vc_arbitration_config_regs
